// File: rsse_alu.sv
`timescale 1ns/1ps
module rsse_alu
	import rsse_pkg::*;
(
	rsse_alu_if.alu bus
);

	always_comb
	begin
		bus.result    = bus.operand;
		bus.carry_out = bus.carry_in;
		bus.flag_upd  = 1'b0;
		bus.carry_upd = 1'b0;
		unique case (bus.op)
			OP_ROT_LEFT_NOCARRY:
			begin
				bus.result   = {bus.operand[6:0], bus.operand[7]}; // RL1
				bus.flag_upd = 1'b1;
			end
			OP_ROT_LEFT_THRU:
			begin
				bus.result    = {bus.operand[6:0], bus.carry_in}; // RL13
				bus.carry_out = bus.operand[7]; // RL13
				bus.flag_upd  = 1'b1;
				bus.carry_upd = 1'b1;
			end
			OP_ROT_RIGHT_THRU:
			begin
				bus.result    = {bus.carry_in, bus.operand[7:1]}; // RL2
				bus.carry_out = bus.operand[0]; // RL2
				bus.flag_upd  = 1'b1;
				bus.carry_upd = 1'b1;
			end
			OP_ROT_RIGHT_NOCARRY:
			begin
				bus.result   = {bus.operand[0], bus.operand[7:1]}; // RL3
				bus.flag_upd = 1'b1;
			end
			OP_SET_ALL_ONES:
				bus.result = ALL_ONES; // RL6
			OP_NONE,
			OP_POWERDOWN:
				bus.result = bus.operand;
		endcase
		bus.neg  = bus.result[7]; // RL14
		bus.zero = (bus.result == 8'h00); // RL14
	end

endmodule // rsse_alu

// File: rsse_alu_if.sv
`timescale 1ns/1ps
interface rsse_alu_if;
	import rsse_pkg::*;
	rsse_op_t   op;
	logic [7:0] operand;
	logic       carry_in;
	logic [7:0] result;
	logic       carry_out;
	logic       neg;
	logic       zero;
	logic       flag_upd;
	logic       carry_upd;

	modport alu (
		input  op, operand, carry_in,
		output result, carry_out, neg, zero, flag_upd, carry_upd
	);
	modport ctrl (
		output op, operand, carry_in,
		input  result, carry_out, neg, zero, flag_upd, carry_upd
	);
endinterface

// File: rsse_chk.sv
`timescale 1ns/1ps
module rsse_chk
	import rsse_pkg::*;
(
	input wire logic       CORE_CLK_I,
	input wire logic       RESET_I,
	input wire logic       PSEL_I,
	input wire logic       PENABLE_I,
	input wire logic       PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic       PREADY_O,
	input wire logic       PSLVERR_O,
	input wire logic       WDT_WAKE_I,
	input wire logic       WAKE_I,
	input wire logic       WDT_CLEAR_O,
	input wire logic       OSC_STOP_O,
	input wire logic       BUSY_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);

	// Refusal is latched a cycle before the commit edge, so look at the error flag too
	sequence s_instr_go;
		PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == OFF_INSTR
			&& !BUSY_O && !OSC_STOP_O && !PSLVERR_O;
	endsequence
	sequence s_instr_refused;
		PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == OFF_INSTR
			&& PSLVERR_O && !BUSY_O;
	endsequence
	sequence s_four_q;
		BUSY_O [*4] ##1 !BUSY_O;
	endsequence
	sequence s_no_wake;
		OSC_STOP_O && !WDT_WAKE_I && !WAKE_I;
	endsequence

	property p_instr_cycle; s_instr_go |=> s_four_q; endproperty
	property p_busy_cause; $rose(BUSY_O) |-> $past(PSEL_I && PENABLE_I && PREADY_O); endproperty
	property p_sleep_enter; $rose(OSC_STOP_O) |-> $fell(BUSY_O); endproperty
	property p_sleep_pulse; $rose(OSC_STOP_O) |-> WDT_CLEAR_O; endproperty
	property p_wdt_clear; WDT_CLEAR_O |-> $rose(OSC_STOP_O) ##1 !WDT_CLEAR_O; endproperty
	// Two quiet samples, as the wake takes effect one cycle late
	property p_sleep_hold; s_no_wake [*2] |=> OSC_STOP_O; endproperty
	property p_wake; OSC_STOP_O && (WDT_WAKE_I || WAKE_I) |-> ##[1:2] !OSC_STOP_O; endproperty
	property p_idle_asleep; OSC_STOP_O |-> !BUSY_O; endproperty
	property p_instr_refused; s_instr_refused |=> !BUSY_O; endproperty

	a_instr_cycle: assert property (p_instr_cycle) else $error("bad cycle");
	a_busy_cause: assert property (p_busy_cause) else $error("busy uncaused");
	a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not in Q4");
	a_sleep_pulse: assert property (p_sleep_pulse) else $error("no clear");
	a_wdt_clear: assert property (p_wdt_clear) else $error("stray clear");
	a_sleep_hold: assert property (p_sleep_hold) else $error("woke alone");
	a_wake: assert property (p_wake) else $error("no wake");
	a_idle_asleep: assert property (p_idle_asleep) else $error("busy asleep");
	a_instr_refused: assert property (p_instr_refused) else $error("refused write ran");
endmodule // rsse_chk

// File: rsse_pkg.sv
package rsse_pkg;

	// APB byte offsets, one aligned word each
	localparam logic [7:0] OFF_INSTR    = 8'h00;
	localparam logic [7:0] OFF_WREG     = 8'h04;
	localparam logic [7:0] OFF_BANKSEL  = 8'h08;
	localparam logic [7:0] OFF_STATUS   = 8'h0c;
	localparam logic [7:0] OFF_MEM_ADDR = 8'h10;
	localparam logic [7:0] OFF_MEM_DATA = 8'h14;

	// Status word bit positions
	localparam int STAT_CARRY     = 0;
	localparam int STAT_ZERO      = 1;
	localparam int STAT_NEGATIVE  = 2;
	localparam int STAT_POWERDOWN = 3;
	localparam int STAT_TIMEOUT   = 4;
	localparam int STAT_BUSY      = 5;
	localparam int STAT_SLEEPING  = 6;

	// Values after reset
	localparam logic       RST_CARRY     = 1'b0;
	localparam logic       RST_ZERO      = 1'b0;
	localparam logic       RST_NEGATIVE  = 1'b0;
	localparam logic       RST_POWERDOWN = 1'b1;
	localparam logic       RST_TIMEOUT   = 1'b1;
	localparam logic [7:0] RST_WREG      = 8'h00;
	localparam logic [15:0] RST_INSTR    = 16'h0000;

	// Instruction encodings and field positions
	localparam logic [5:0]  ENC_ROT_LEFT_NOCARRY   = 6'h11;
	localparam logic [5:0]  ENC_ROT_RIGHT_NOCARRY  = 6'h10;
	localparam logic [5:0]  ENC_ROT_LEFT_THRU      = 6'h0d;
	localparam logic [5:0]  ENC_ROT_RIGHT_THRU     = 6'h0c;
	localparam logic [6:0]  ENC_SET_ALL_ONES       = 7'h34;
	localparam logic [15:0] ENC_POWERDOWN          = 16'h0003;
	localparam int          POS_DEST   = 9;
	localparam int          POS_ACCESS = 8;
	localparam logic [7:0]  ALL_ONES   = 8'hff;

	// Bank used when the access bit is clear
	localparam int ACCESS_BANK = 0;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_ROT_LEFT_NOCARRY,
		OP_ROT_LEFT_THRU,
		OP_ROT_RIGHT_THRU,
		OP_ROT_RIGHT_NOCARRY,
		OP_SET_ALL_ONES,
		OP_POWERDOWN
	} rsse_op_t;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} rsse_phase_t;

	function automatic rsse_op_t rsse_decode(input logic [15:0] instr);
		rsse_op_t op;
		op = OP_NONE;
		if (instr == ENC_POWERDOWN)
			op = OP_POWERDOWN;
		else if (instr[15:9] == ENC_SET_ALL_ONES)
			op = OP_SET_ALL_ONES;
		else if (instr[15:10] == ENC_ROT_LEFT_NOCARRY)
			op = OP_ROT_LEFT_NOCARRY;
		else if (instr[15:10] == ENC_ROT_RIGHT_NOCARRY)
			op = OP_ROT_RIGHT_NOCARRY;
		else if (instr[15:10] == ENC_ROT_LEFT_THRU)
			op = OP_ROT_LEFT_THRU;
		else if (instr[15:10] == ENC_ROT_RIGHT_THRU)
			op = OP_ROT_RIGHT_THRU;
		return op;
	endfunction

endpackage

// File: rsse_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module testbench;
	import rsse_pkg::*;
	logic        clk   = 1'b0;
	logic        rst   = 1'b1;
	logic        psel  = 1'b0;
	logic        pen   = 1'b0;
	logic        pwr   = 1'b0;
	logic [7:0]  padr  = 8'h00;
	logic [31:0] pwd   = 32'h0;
	logic        wwake = 1'b0;
	logic        wake  = 1'b0;
	logic [31:0] prd, rv;
	logic        rdy, err, clr, stop, busy, d, a, c, nc, ev;
	logic [7:0]  v, r, f;
	logic [2:0]  sf;
	logic [8:0]  tgt;
	logic [15:0] ins;
	int          errors     = 0;
	int          num_checks = 0;
	int          cyc        = 0;

	always #2 clk = ~clk;

	rsse_top #(.BANK_W(1)) i_dut (.CORE_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
		.PREADY_O(rdy), .PSLVERR_O(err), .WDT_WAKE_I(wwake), .WAKE_I(wake),
		.WDT_CLEAR_O(clr), .OSC_STOP_O(stop), .BUSY_O(busy));

	task automatic print_verdict();
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Request held until the edge that sees ready; data and error taken there
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= ad;
		pwd <= wd;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rv = prd;
		ev = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic run(input logic [15:0] code);
		apb(1'b1, OFF_INSTR, {16'h0, code});
		do @(posedge clk); while (busy === 1'b1);
	endtask

	task automatic mem(input logic w, input logic [8:0] ad, input logic [7:0] wd);
		apb(1'b1, OFF_MEM_ADDR, {23'h0, ad});
		apb(w, OFF_MEM_DATA, {24'h0, wd});
	endtask

	task automatic pulse(input logic wd);
		@(posedge clk);
		wwake <= wd;
		wake <= ~wd;
		@(posedge clk);
		wwake <= 1'b0;
		wake <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			print_verdict();
		end
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		apb(1'b1, OFF_BANKSEL, 32'h1);
		f = 8'h25;
		for (int k = 0; k < 5; k++)
		begin
			for (int i = 0; i < 2; i++)
			begin
				d = i[0];
				a = ~i[0];
				c = i[0];
				v = i[0] ? 8'h00 : 8'hab;
				tgt = {a, f};
				mem(1'b1, tgt, v);
				mem(1'b1, {~a, f}, ~v);
				apb(1'b1, OFF_WREG, 32'h5a);
				apb(1'b1, OFF_STATUS, {29'h0, 2'b10, c});
				case (k)
					0: begin ins = {ENC_ROT_LEFT_NOCARRY, d, a, f}; r = {v[6:0], v[7]}; nc = c; end
					1: begin ins = {ENC_ROT_LEFT_THRU, d, a, f}; r = {v[6:0], c}; nc = v[7]; end
					2: begin ins = {ENC_ROT_RIGHT_THRU, d, a, f}; r = {c, v[7:1]}; nc = v[0]; end
					3: begin ins = {ENC_ROT_RIGHT_NOCARRY, d, a, f}; r = {v[0], v[7:1]}; nc = c; end
					default: begin ins = {ENC_SET_ALL_ONES, a, f}; r = 8'hff; nc = c; end
				endcase
				sf = (k == 4) ? {2'b10, c} : {r[7], r == 8'h00, nc};
				run(ins);
				apb(1'b0, OFF_STATUS, 32'h0);
				`CHK(rv, {27'h3, sf})
				mem(1'b0, tgt, 8'h00);
				`CHK(rv[7:0], (d || k == 4) ? r : v)
				apb(1'b0, OFF_WREG, 32'h0);
				`CHK(rv[7:0], (d || k == 4) ? 8'h5a : r)
				mem(1'b0, {~a, f}, 8'h00);
				`CHK(rv[7:0], ~v)
			end
		end
		run(ENC_POWERDOWN);
		`CHK(stop, 1'b1)
		`CHK(clr, 1'b1)
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK(rv[6:3], 4'b1010)
		apb(1'b1, OFF_INSTR, {16'h0, ENC_SET_ALL_ONES, 1'b0, f});
		`CHK(ev, 1'b1)
		@(posedge clk);
		`CHK(busy, 1'b0)
		pulse(1'b0);
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK(rv[6:3], 4'b0010)
		run(ENC_POWERDOWN);
		pulse(1'b1);
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK(rv[6:3], 4'b0000)
		print_verdict();
	end
endmodule // testbench

bind rsse_top rsse_chk i_chk (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O),
	.WDT_WAKE_I(WDT_WAKE_I), .WAKE_I(WAKE_I), .WDT_CLEAR_O(WDT_CLEAR_O),
	.OSC_STOP_O(OSC_STOP_O), .BUSY_O(BUSY_O));

// File: rsse_top.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
// Summary of operation
// [RL1] Rotate left without carry; old bit 7 to bit 0; negative, zero only.
// [RL2] Rotate right through carry; bit 0 to carry, carry to bit 7.
// [RL3] Rotate right without carry; old bit 0 to bit 7; carry kept.
// [RL4] Destination bit 0 writes working register, 1 writes source register.
// [RL5] Access bit 0 uses fixed bank, 1 uses bank select register.
// [RL6] Set-register instruction writes all ones, no status flag changes.
// [RL7] One word, one instruction cycle: decode, read, process, write.
// [RL8] Power-down instruction clears the power-down flag.
// [RL9] Power-down instruction sets the timeout flag.
// [RL10] Power-down instruction clears watchdog counter and its postscaler.
// [RL11] Power-down enters sleep and stops oscillator in phase four.
// [RL12] Watchdog wake-up from sleep clears the timeout flag.
// [RL13] Rotate left through carry; bit 7 to carry, carry to bit 0.
// [RL14] Negative equals result bit 7; zero set when result is zero.
module rsse_top
	import rsse_pkg::*;
#(
	parameter int BANK_W = 1
)
(
	input  wire logic        CORE_CLK_I,
	input  wire logic        RESET_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        WDT_WAKE_I,
	input  wire logic        WAKE_I,
	output logic             WDT_CLEAR_O,
	output logic             OSC_STOP_O,
	output logic             BUSY_O
);

	localparam int ADDR_W = BANK_W + 8;
	localparam int DEPTH  = 1 << ADDR_W;

	typedef struct packed {
		logic              ack;
		logic              err;
		logic [31:0]       rdata;
		rsse_phase_t       ph;
		rsse_op_t          op;
		logic [15:0]       instr;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        opnd;
		logic [7:0]        res;
		logic              c_res;
		logic              n_res;
		logic              z_res;
		logic [7:0]        wreg;
		logic [BANK_W-1:0] bank;
		logic              carry;
		logic              zero;
		logic              neg;
		logic              powerdown_flag;
		logic              timeout_flag;
		logic              sleeping;
		logic              wdt_clr;
		logic [ADDR_W-1:0] maddr;
	} rsse_state_t;

	rsse_state_t       s_r;
	rsse_state_t       s_nxt;
	logic [7:0]        mem [DEPTH];
	logic              mem_we;
	logic [ADDR_W-1:0] mem_wa;
	logic [7:0]        mem_wd;
	logic              busy;
	logic              access;
	logic              mapped;
	logic              refuse;
	logic [31:0]       rd_word;
	logic [7:0]        status_byte;

	rsse_alu_if alu_bus ();

	rsse_alu u_alu (
		.bus (alu_bus)
	);

	assign busy = (s_r.ph != PH_IDLE);

	assign alu_bus.op       = s_r.op;
	assign alu_bus.operand  = s_r.opnd;
	assign alu_bus.carry_in = s_r.carry;

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[STAT_CARRY]     = s_r.carry;
		status_byte[STAT_ZERO]      = s_r.zero;
		status_byte[STAT_NEGATIVE]  = s_r.neg;
		status_byte[STAT_POWERDOWN] = s_r.powerdown_flag;
		status_byte[STAT_TIMEOUT]   = s_r.timeout_flag;
		status_byte[STAT_BUSY]      = busy;
		status_byte[STAT_SLEEPING]  = s_r.sleeping;
	end

	// Read mux and refusal check, evaluated in the first access cycle
	always_comb
	begin
		mapped  = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (PADDR_I)
			OFF_INSTR:    rd_word[15:0] = s_r.instr;
			OFF_WREG:     rd_word[7:0] = s_r.wreg;
			OFF_BANKSEL:  rd_word[BANK_W-1:0] = s_r.bank;
			OFF_STATUS:   rd_word[7:0] = status_byte;
			OFF_MEM_ADDR: rd_word[ADDR_W-1:0] = s_r.maddr;
			OFF_MEM_DATA: rd_word[7:0] = mem[s_r.maddr];
			default:      mapped = 1'b0;
		endcase
		refuse = !mapped;
		// Core is halted while asleep; one instruction at a time
		if (PWRITE_I && PADDR_I == OFF_INSTR && (busy || s_r.sleeping))
			refuse = 1'b1;
		// Avoids a second writer on the data memory during execution
		if (PWRITE_I && PADDR_I == OFF_MEM_DATA && busy)
			refuse = 1'b1;
		if (refuse || PWRITE_I)
			rd_word = 32'h0000_0000;
	end

	assign access = PSEL_I && PENABLE_I;

	always_comb
	begin
		s_nxt         = s_r;
		s_nxt.wdt_clr = 1'b0;
		mem_we        = 1'b0;
		mem_wa        = s_r.maddr;
		mem_wd        = PWDATA_I[7:0];

		// APB: answer one cycle into the access phase, commit at the ready edge
		if (s_r.ack)
		begin
			s_nxt.ack = 1'b0;
			if (access && PWRITE_I && !s_r.err)
			begin
				unique case (PADDR_I)
					OFF_INSTR:
					begin
						s_nxt.instr = PWDATA_I[15:0];
						s_nxt.ph    = PH_Q1;
					end
					OFF_WREG:
						s_nxt.wreg = PWDATA_I[7:0];
					OFF_BANKSEL:
						s_nxt.bank = PWDATA_I[BANK_W-1:0];
					OFF_STATUS:
					begin
						s_nxt.carry = PWDATA_I[STAT_CARRY];
						s_nxt.zero  = PWDATA_I[STAT_ZERO];
						s_nxt.neg   = PWDATA_I[STAT_NEGATIVE];
					end
					OFF_MEM_ADDR:
						s_nxt.maddr = PWDATA_I[ADDR_W-1:0];
					OFF_MEM_DATA:
						mem_we = 1'b1;
					default:
						s_nxt.maddr = s_r.maddr;
				endcase
			end
		end
		else if (access)
		begin
			s_nxt.ack   = 1'b1;
			s_nxt.err   = refuse;
			s_nxt.rdata = rd_word;
		end

		// Instruction cycle; placed after the bus so hardware updates win
		unique case (s_r.ph)
			PH_IDLE:
				s_nxt.ph = s_nxt.ph;
			PH_Q1:
			begin
				s_nxt.op = rsse_decode(s_r.instr); // RL7
				if (s_r.instr[POS_ACCESS])
					s_nxt.addr = {s_r.bank, s_r.instr[7:0]}; // RL5
				else
					s_nxt.addr = {ACCESS_BANK[BANK_W-1:0], s_r.instr[7:0]}; // RL5
				s_nxt.ph = PH_Q2;
			end
			PH_Q2:
			begin
				// Power-down does nothing in this phase
				if (s_r.op != OP_POWERDOWN)
					s_nxt.opnd = mem[s_r.addr]; // RL7
				s_nxt.ph = PH_Q3;
			end
			PH_Q3:
			begin
				s_nxt.res   = alu_bus.result; // RL7
				s_nxt.c_res = alu_bus.carry_out;
				s_nxt.n_res = alu_bus.neg;
				s_nxt.z_res = alu_bus.zero;
				s_nxt.ph    = PH_Q4;
			end
			PH_Q4:
			begin
				s_nxt.ph = PH_IDLE; // RL7
				unique case (s_r.op)
					OP_ROT_LEFT_NOCARRY,
					OP_ROT_LEFT_THRU,
					OP_ROT_RIGHT_THRU,
					OP_ROT_RIGHT_NOCARRY:
					begin
						if (s_r.instr[POS_DEST])
						begin
							mem_we = 1'b1; // RL4
							mem_wa = s_r.addr;
							mem_wd = s_r.res;
						end
						else
							s_nxt.wreg = s_r.res; // RL4
						s_nxt.neg  = s_r.n_res; // RL14
						s_nxt.zero = s_r.z_res; // RL14
						if (alu_bus.carry_upd)
							s_nxt.carry = s_r.c_res; // RL2 RL13
					end
					OP_SET_ALL_ONES:
					begin
						mem_we = 1'b1; // RL6
						mem_wa = s_r.addr;
						mem_wd = s_r.res;
					end
					OP_POWERDOWN:
					begin
						s_nxt.powerdown_flag = 1'b0; // RL8
						s_nxt.timeout_flag   = 1'b1; // RL9
						s_nxt.wdt_clr        = 1'b1; // RL10
						s_nxt.sleeping       = 1'b1; // RL11
					end
					OP_NONE:
						s_nxt.op = OP_NONE;
				endcase
			end
		endcase

		// Wake only counts once sleep has really begun
		if (s_r.sleeping && (WDT_WAKE_I || WAKE_I))
		begin
			s_nxt.sleeping = 1'b0;
			if (WDT_WAKE_I)
				s_nxt.timeout_flag = 1'b0; // RL12
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
		begin
			s_r                <= '0;
			s_r.ph             <= PH_IDLE;
			s_r.op             <= OP_NONE;
			s_r.instr          <= RST_INSTR;
			s_r.wreg           <= RST_WREG;
			s_r.carry          <= RST_CARRY;
			s_r.zero           <= RST_ZERO;
			s_r.neg            <= RST_NEGATIVE;
			s_r.powerdown_flag <= RST_POWERDOWN;
			s_r.timeout_flag   <= RST_TIMEOUT;
		end
		else
			s_r <= s_nxt;
		// Data memory has no reset; contents are software's business
		if (mem_we && !RESET_I)
			mem[mem_wa] <= mem_wd;
	end

	assign PRDATA_O    = s_r.rdata;
	assign PREADY_O    = s_r.ack;
	assign PSLVERR_O   = s_r.ack && s_r.err;
	assign WDT_CLEAR_O = s_r.wdt_clr;
	assign OSC_STOP_O  = s_r.sleeping;
	assign BUSY_O      = busy;

endmodule // rsse_top
